// ===== rtl/cor_regs.sv
`timescale 1ns/1ps
`include "cor_cfg.svh"
module cor_regs
    import cor_pkg::*;
#(
    parameter int         RAW_W        = 12,
    parameter int         BUS_W        = 24,
    // Identification characters: values are arbitrary
    parameter logic [7:0] ID_TWO       = 8'h41,
    parameter logic [7:0] ID_THREE_CAP = 8'h43,
    parameter logic [7:0] ID_THREE_STD = 8'h44,
    parameter logic [7:0] ID_FOUR      = 8'h31,
    parameter logic [7:0] ID_FIVE      = 8'h32,
    parameter logic [7:0] ID_SIX       = 8'h33,
    parameter bit         DECRYPT_CAP  = 1'b1
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite write address
    input  wire logic [9:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [9:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Pass indication from the output datapath (asynchronous)
    input  wire logic             pass_in,
    // Raw pixel data
    input  wire logic [RAW_W-1:0] raw_pixel,
    output logic      [BUS_W-1:0] pixel_bus,
    // Output controls
    output logic                  port_zero_on,
    output logic                  port_one_on,
    output logic [1:0]            virtual_channel,
    // General pins, output and enable
    output logic                  general_pin_zero_o,
    output logic                  general_pin_zero_oe,
    output logic                  general_pin_three_o,
    output logic                  general_pin_three_oe
);
    // Elaboration checks: the aligner needs a raw word that fits the bus
    if (RAW_W < 1) begin : g_raw_w_bad
        $error("RAW_W must be at least 1");
    end
    if (BUS_W < RAW_W) begin : g_bus_w_bad
        $error("BUS_W must be at least RAW_W");
    end

    function automatic bit is_printable(input logic [7:0] c);
        return (c >= 8'h20) && (c <= 8'h7E);
    endfunction
    if (!is_printable(ID_TWO) || !is_printable(ID_THREE_CAP) ||
        !is_printable(ID_THREE_STD) || !is_printable(ID_FOUR) ||
        !is_printable(ID_FIVE) || !is_printable(ID_SIX)) begin : g_id_bad
        $error("identification bytes must be printable characters");
    end
    if (ID_THREE_CAP == ID_THREE_STD) begin : g_id_three_bad
        $error("the two third-byte characters must differ");
    end

    typedef struct packed {
        cor_regs_t     regs;
        cor_wr_state_t wst;
        logic [7:0]    waddr;
        logic          have_aw;
        logic [7:0]    wdat;
        logic          wbyte0;
        logic          have_w;
        logic [1:0]    bresp;
        cor_rd_state_t rst;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
        logic [BUS_W-1:0] pix;
        logic          p0_on;
        logic          p1_on;
        logic          pin0;
        logic          pin0_oe;
        logic          pin3;
        logic          pin3_oe;
        // Handshake outputs kept in flops so no port is decoded
        logic          aw_rdy;
        logic          w_rdy;
        logic          b_vld;
        logic          ar_rdy;
        logic          r_vld;
    } cor_state_t;

    cor_state_t st;
    cor_state_t next_st;
    logic       pass_sync;
    logic [BUS_W-1:0] aligned;

    // Whole-word index from a byte address; low two bits are ignored
    function automatic logic [7:0] word_index(input logic [9:0] a);
        return a[9:2];
    endfunction

    // Known, writable register?
    function automatic logic is_writable(input logic [7:0] i);
        return (i == `COR_IDX_RAW_ALIGN) || (i == `COR_IDX_PORT0_EN) ||
               (i == `COR_IDX_PORT1_EN) || (i == `COR_IDX_PASS_ROUTE) ||
               (i == `COR_IDX_VC_SEL);
    endfunction

    // Keep reserved bits at their reset value
    function automatic logic [7:0] merge(input logic [7:0] rst_v,
                                         input logic [7:0] mask,
                                         input logic [7:0] d);
        return (d & mask) | (rst_v & ~mask);
    endfunction

    // With bit 7 set, port is on only for the all-ones pattern in bits 5:0; bit 7 clear gives the default
    function automatic logic port_enabled(input logic [7:0] r, input logic dflt);
        logic on;
        on = dflt;
        if (r[`COR_EN_CTRL_BIT]) begin
            on = (r[`COR_EN_FIELD_HI:0] == `COR_EN_ALL);
        end
        return on;
    endfunction

    // Pin enable and level for one routing bit; unrouted pins idle low
    function automatic logic [1:0] route_pin(input logic sel, input logic pass);
        return {sel, sel & pass};
    endfunction

    // New register image for one accepted byte; reserved bits keep reset value
    function automatic cor_regs_t write_commit(input cor_regs_t  r,
                                               input logic [7:0] idx,
                                               input logic [7:0] d);
        cor_regs_t n;
        n = r;
        case (idx)
            `COR_IDX_RAW_ALIGN:
                n.raw_pixel_alignment = merge(`COR_RST_RAW_ALIGN, `COR_MASK_RAW_ALIGN, d);
            `COR_IDX_PORT0_EN:
                n.output_port_zero_enable = merge(`COR_RST_PORT0_EN, `COR_MASK_PORT_EN, d);
            `COR_IDX_PORT1_EN:
                n.output_port_one_enable = merge(`COR_RST_PORT1_EN, `COR_MASK_PORT_EN, d);
            `COR_IDX_PASS_ROUTE:
                n.pass_indicator_routing = merge(`COR_RST_PASS_ROUTE, `COR_MASK_PASS_ROUTE, d);
            `COR_IDX_VC_SEL:
                n.virtual_channel_select = merge(`COR_RST_VC_SEL, `COR_MASK_VC_SEL, d);
            // Identification and unmapped words: nothing to store
            default: ;
        endcase
        return n;
    endfunction

    // Read value and whether the word exists; unmapped words read zero
    function automatic logic [8:0] read_word(input logic [7:0] idx,
                                             input cor_regs_t  r,
                                             input logic       pass);
        logic [7:0] v;
        logic       ok;
        v  = 8'h00;
        ok = 1'b1;
        case (idx)
            `COR_IDX_RAW_ALIGN:  v = r.raw_pixel_alignment;
            `COR_IDX_PORT0_EN:   v = r.output_port_zero_enable;
            `COR_IDX_PORT1_EN:   v = r.output_port_one_enable;
            `COR_IDX_PASS_ROUTE: begin
                v = r.pass_indicator_routing;
                v[`COR_PASS_STAT_BIT] = pass;
            end
            `COR_IDX_VC_SEL:     v = r.virtual_channel_select;
            `COR_IDX_ID_TWO:     v = ID_TWO;
            `COR_IDX_ID_THREE:   v = DECRYPT_CAP ? ID_THREE_CAP : ID_THREE_STD;
            `COR_IDX_ID_FOUR:    v = ID_FOUR;
            `COR_IDX_ID_FIVE:    v = ID_FIVE;
            `COR_IDX_ID_SIX:     v = ID_SIX;
            default:             ok = 1'b0;
        endcase
        return {ok, v};
    endfunction

    // Pass comes from another domain; two flops before any logic reads it
    cor_sync u_pass_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (pass_in),
        .dout    (pass_sync)
    );

    cor_pixel_align #(
        .RAW_W (RAW_W),
        .BUS_W (BUS_W)
    ) u_align (
        .msb_align (st.regs.raw_pixel_alignment[`COR_RAW_ALIGN_BIT]),
        .raw_in    (raw_pixel),
        .bus_out   (aligned)
    );

    always_comb begin
        logic [7:0] ridx;
        logic [7:0] rv;
        logic       rok;
        // Read index decoded every cycle; the value is kept only on accept
        ridx       = word_index(s_axi_araddr);
        {rok, rv}  = read_word(ridx, st.regs, pass_sync);
        next_st    = st;

        // Write channel: take address and data in either order
        // Each half waits in its own holding flop until the other arrives
        if (s_axi_awvalid && !st.have_aw && st.wst == COR_WR_IDLE) begin
            next_st.have_aw = 1'b1;
            next_st.waddr   = word_index(s_axi_awaddr);
        end
        if (s_axi_wvalid && !st.have_w && st.wst == COR_WR_IDLE) begin
            next_st.have_w = 1'b1;
            next_st.wdat   = s_axi_wdata[7:0];
            next_st.wbyte0 = s_axi_wstrb[0];
        end
        case (st.wst)
            COR_WR_IDLE: begin
                if (st.have_aw && st.have_w) begin
                    next_st.wst     = COR_WR_RESP;
                    next_st.have_aw = 1'b0;
                    next_st.have_w  = 1'b0;
                    // Read-only and unmapped words answer SLVERR and store nothing
                    next_st.bresp   = is_writable(st.waddr) ? `COR_RESP_OKAY
                                                            : `COR_RESP_SLVERR;
                    // Strobe low is still answered, but nothing is stored
                    if (st.wbyte0) begin
                        next_st.regs = write_commit(st.regs, st.waddr, st.wdat);
                    end
                end
            end
            COR_WR_RESP: begin
                if (s_axi_bready) begin
                    next_st.wst = COR_WR_IDLE;
                end
            end
            default: next_st.wst = COR_WR_IDLE;
        endcase

        // Read data captured on accept, so it cannot move while rvalid stands
        case (st.rst)
            COR_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    next_st.rst   = COR_RD_DATA;
                    next_st.rdata = {24'h000000, rv};
                    next_st.rresp = rok ? `COR_RESP_OKAY : `COR_RESP_SLVERR;
                end
            end
            COR_RD_DATA: begin
                if (s_axi_rready) begin
                    next_st.rst = COR_RD_IDLE;
                end
            end
            default: next_st.rst = COR_RD_IDLE;
        endcase

        // Handshake outputs come from flops; none is decoded at the port
        next_st.aw_rdy = (next_st.wst == COR_WR_IDLE) && !next_st.have_aw;
        next_st.w_rdy  = (next_st.wst == COR_WR_IDLE) && !next_st.have_w;
        next_st.b_vld  = (next_st.wst == COR_WR_RESP);
        next_st.ar_rdy = (next_st.rst == COR_RD_IDLE);
        next_st.r_vld  = (next_st.rst == COR_RD_DATA);

        next_st.pix   = aligned;
        next_st.p0_on = port_enabled(st.regs.output_port_zero_enable, 1'b1);
        next_st.p1_on = port_enabled(st.regs.output_port_one_enable, 1'b0);
        {next_st.pin3_oe, next_st.pin3} =
            route_pin(st.regs.pass_indicator_routing[`COR_PASS_PIN3_BIT], pass_sync);
        {next_st.pin0_oe, next_st.pin0} =
            route_pin(st.regs.pass_indicator_routing[`COR_PASS_PIN0_BIT], pass_sync);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st                                <= '0;
            st.regs.raw_pixel_alignment       <= `COR_RST_RAW_ALIGN;
            st.regs.output_port_zero_enable   <= `COR_RST_PORT0_EN;
            st.regs.output_port_one_enable    <= `COR_RST_PORT1_EN;
            st.regs.pass_indicator_routing    <= `COR_RST_PASS_ROUTE;
            st.regs.virtual_channel_select    <= `COR_RST_VC_SEL;
            st.wst                            <= COR_WR_IDLE;
            st.rst                            <= COR_RD_IDLE;
            // Port zero, pin zero and bus readies leave reset at their defaults
            st.p0_on                          <= 1'b1;
            st.pin0_oe                        <= 1'b1;
            st.aw_rdy                         <= 1'b1;
            st.w_rdy                          <= 1'b1;
            st.ar_rdy                         <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready        = st.aw_rdy;
    assign s_axi_wready         = st.w_rdy;
    assign s_axi_bvalid         = st.b_vld;
    assign s_axi_bresp          = st.bresp;
    assign s_axi_arready        = st.ar_rdy;
    assign s_axi_rvalid         = st.r_vld;
    assign s_axi_rdata          = st.rdata;
    assign s_axi_rresp          = st.rresp;
    assign pixel_bus            = st.pix;
    assign port_zero_on         = st.p0_on;
    assign port_one_on          = st.p1_on;
    assign virtual_channel      = st.regs.virtual_channel_select[`COR_VC_HI:`COR_VC_LO];
    assign general_pin_zero_o   = st.pin0;
    assign general_pin_zero_oe  = st.pin0_oe;
    assign general_pin_three_o  = st.pin3;
    assign general_pin_three_oe = st.pin3_oe;
endmodule

// ===== rtl/cor_cfg.svh
`ifndef COR_CFG_SVH
`define COR_CFG_SVH

// Register indices (byte address is four times the index)
`define COR_IDX_RAW_ALIGN     8'h09
`define COR_IDX_PORT0_EN      8'h13
`define COR_IDX_PORT1_EN      8'h14
`define COR_IDX_PASS_ROUTE    8'h16
`define COR_IDX_VC_SEL        8'h2E
`define COR_IDX_ID_TWO        8'hF1
`define COR_IDX_ID_THREE      8'hF2
`define COR_IDX_ID_FOUR       8'hF3
`define COR_IDX_ID_FIVE       8'hF4
`define COR_IDX_ID_SIX        8'hF5

// Field positions
`define COR_RAW_ALIGN_BIT     4
`define COR_EN_CTRL_BIT       7
`define COR_EN_FIELD_HI       5
`define COR_PASS_PIN3_BIT     2
`define COR_PASS_PIN0_BIT     1
`define COR_PASS_STAT_BIT     0
`define COR_VC_HI             7
`define COR_VC_LO             6

// Reset values
`define COR_RST_RAW_ALIGN     8'h00
`define COR_RST_PORT0_EN      8'h3F
`define COR_RST_PORT1_EN      8'h00
`define COR_RST_PASS_ROUTE    8'h02
`define COR_RST_VC_SEL        8'h00
`define COR_EN_ALL            6'h3F
`define COR_EN_NONE           6'h00

// Writable masks; other bits hold reset value
`define COR_MASK_RAW_ALIGN    8'h10
`define COR_MASK_PORT_EN      8'hBF
`define COR_MASK_PASS_ROUTE   8'h06
`define COR_MASK_VC_SEL       8'hC0

// AXI responses
`define COR_RESP_OKAY         2'h0
`define COR_RESP_SLVERR       2'h2

`endif

// ===== rtl/cor_pkg.sv
package cor_pkg;
    typedef enum logic [1:0] {COR_WR_IDLE, COR_WR_RESP} cor_wr_state_t;
    typedef enum logic [0:0] {COR_RD_IDLE, COR_RD_DATA} cor_rd_state_t;
    typedef struct packed {
        logic [7:0] raw_pixel_alignment;
        logic [7:0] output_port_zero_enable;
        logic [7:0] output_port_one_enable;
        logic [7:0] pass_indicator_routing;
        logic [7:0] virtual_channel_select;
    } cor_regs_t;
endpackage

// ===== rtl/cor_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser; first stage feeds only the second
module cor_sync (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Data
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } cor_sync_st_t;

    cor_sync_st_t st;
    cor_sync_st_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.s2;
endmodule

// ===== rtl/cor_pixel_align.sv
`timescale 1ns/1ps
`include "cor_cfg.svh"
// Places raw pixel data on low or high bits of the colour bus
module cor_pixel_align #(
    parameter int RAW_W = 12,
    parameter int BUS_W = 24
) (
    // Control
    input  wire logic             msb_align,
    // Data
    input  wire logic [RAW_W-1:0] raw_in,
    output logic      [BUS_W-1:0] bus_out
);
    // Elaboration check: the raw word must fit the bus
    if (RAW_W < 1 || RAW_W > BUS_W) begin : g_width_bad
        $error("RAW_W must be 1..BUS_W");
    end

    always_comb begin
        bus_out = '0;
        if (msb_align) begin
            bus_out[BUS_W-1 -: RAW_W] = raw_in;
        end else begin
            bus_out[RAW_W-1:0] = raw_in;
        end
    end
endmodule

// ===== test/cor_regs_props.sv
`timescale 1ns/1ps
module cor_regs_chk #(
    parameter int RAW_W = 12,
    parameter int BUS_W = 24
) (
    // Clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // Bus handshakes
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    // Outputs
    input wire logic [BUS_W-1:0] pixel_bus,
    input wire logic             port_one_on,
    input wire logic             general_pin_zero_o,
    input wire logic             general_pin_zero_oe,
    input wire logic             general_pin_three_o,
    input wire logic             general_pin_three_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rdata_byte_only: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_pixel_layout: assert property ((pixel_bus[BUS_W-1:RAW_W] == '0)
        || (pixel_bus[BUS_W-RAW_W-1:0] == '0))
        else $error("pixel bus not aligned");
    a_pin_zero_gate: assert property (!general_pin_zero_oe |-> !general_pin_zero_o)
        else $error("pin zero driven while unrouted");
    a_pin_three_gate: assert property (!general_pin_three_oe |-> !general_pin_three_o)
        else $error("pin three driven while unrouted");
    a_port_one_reset: assert property ($past(!aresetn) |-> !port_one_on)
        else $error("port one on after reset");
endmodule

bind cor_regs cor_regs_chk #(.RAW_W(RAW_W), .BUS_W(BUS_W)) chk_u (.*);

// ===== test/cor_regs_test.sv
`timescale 1ns/1ps
`include "cor_cfg.svh"
module cor_regs_test;
    import cor_pkg::*;
    logic        aclk = 0, aresetn = 0, pass_in = 0;
    logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, virtual_channel;
    logic [11:0] raw_pixel = 12'hABC;
    logic [23:0] pixel_bus;
    logic        port_zero_on, port_one_on, p0_o, p0_oe, p3_o, p3_oe;
    int          error_cnt = 0, n_compared = 0;
    localparam logic [1:0] OK = `COR_RESP_OKAY, SE = `COR_RESP_SLVERR;
    // Identification values are arbitrary
    localparam logic [7:0] ID [5] = '{8'h61, 8'h62, 8'h63, 8'h64, 8'h65};

    always #2 aclk = ~aclk;

    cor_regs #(.ID_TWO(ID[0]), .ID_THREE_CAP(8'h5A), .ID_THREE_STD(ID[1]), .ID_FOUR(ID[2]),
        .ID_FIVE(ID[3]), .ID_SIX(ID[4]), .DECRYPT_CAP(1'b0)) dut_u (.*,
        .general_pin_zero_o(p0_o), .general_pin_zero_oe(p0_oe),
        .general_pin_three_o(p3_o), .general_pin_three_oe(p3_oe));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        // No cycle count assumed: loops until bvalid; only the watchdog bounds this wait
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        chk(s_axi_rdata, {24'h000000, d});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
    endtask

    task automatic report_and_stop();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #80000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        int v;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`COR_IDX_RAW_ALIGN, 8'h00, OK);
        rd(`COR_IDX_PORT0_EN, 8'h3F, OK);
        rd(`COR_IDX_PORT1_EN, 8'h00, OK);
        rd(`COR_IDX_PASS_ROUTE, 8'h02, OK);
        rd(`COR_IDX_VC_SEL, 8'h00, OK);
        chk({port_zero_on, port_one_on, p0_oe, p3_oe}, 4'b1010);
        for (v = 0; v < 5; v++) rd(8'hF1 + v[7:0], ID[v], OK);
        // Third byte picks the non-decrypting character
        rd(`COR_IDX_ID_THREE, ID[1], OK);
        wr(`COR_IDX_ID_FOUR, 8'h00, SE);
        rd(`COR_IDX_ID_FOUR, ID[2], OK);
        rd(8'hF0, 8'h00, SE);
        wr(`COR_IDX_RAW_ALIGN, 8'hFF, OK);
        rd(`COR_IDX_RAW_ALIGN, 8'h10, OK);
        repeat (3) @(posedge aclk);
        chk(pixel_bus, 24'hABC000);
        wr(`COR_IDX_RAW_ALIGN, 8'h00, OK);
        repeat (3) @(posedge aclk);
        chk(pixel_bus, 24'h000ABC);
        wr(`COR_IDX_PORT0_EN, 8'h80, OK);
        repeat (3) @(posedge aclk);
        chk(port_zero_on, 1'b0);
        wr(`COR_IDX_PORT0_EN, 8'hBF, OK);
        wr(`COR_IDX_PORT1_EN, 8'hFF, OK);
        rd(`COR_IDX_PORT1_EN, 8'hBF, OK);
        repeat (3) @(posedge aclk);
        chk({port_zero_on, port_one_on}, 2'b11);
        // Strobe low must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(`COR_IDX_PORT1_EN, 8'h80, OK);
        s_axi_wstrb <= 4'hF;
        rd(`COR_IDX_PORT1_EN, 8'hBF, OK);
        for (v = 0; v < 4; v++) begin
            wr(`COR_IDX_VC_SEL, {v[1:0], 6'h3F}, OK);
            rd(`COR_IDX_VC_SEL, {v[1:0], 6'h00}, OK);
            repeat (2) @(posedge aclk);
            chk(virtual_channel, v[1:0]);
        end
        pass_in <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(`COR_IDX_PASS_ROUTE, 8'h03, OK);
        chk({p0_o, p0_oe, p3_o, p3_oe}, 4'b1100);
        wr(`COR_IDX_PASS_ROUTE, 8'hFC, OK);
        repeat (3) @(posedge aclk);
        chk({p0_o, p0_oe, p3_o, p3_oe}, 4'b0011);
        rd(`COR_IDX_PASS_ROUTE, 8'h05, OK);
        pass_in <= 1'b0;
        repeat (6) @(posedge aclk);
        rd(`COR_IDX_PASS_ROUTE, 8'h04, OK);
        chk({p3_o, p3_oe}, 2'b01);
        report_and_stop();
    end
endmodule
